// File: hdl/charger_supervisor_regs.svh
// register offsets, field positions, reset values and timing figures
// assumes a 100 MHz control clock and an external serial register port
// Functional notes
// - boost variants offer charge, boost, high-z; others only charge and high-z
// - high-z mode halts charge and boost and keeps the converter off
// - without host traffic start fifteen-minute timer and default mode; the code enters default mode but implements no timer
// - fifteen-minute mode charges using reset defaults of all configuration
// - host traffic selects host mode; host then steers operating modes
// - input overvoltage: converter off, fault bits set, fault pulse sent
// - input below overvoltage exit clears fault and charging resumes
// - input power-on enables input current sink for adaptor detection
// - input above minimum for qualification interval means good adaptor
// - input below minimum in detection: sink off, pulse, code 011
// - after bad adaptor wait retry delay then detect again
// - sleep when input below battery plus offset yet above minimum
// - sleep turns off reverse-block switch and converter
// - at dpm threshold reduce charge current to hold the input up
// - while dpm limits current set special-charger flag bit 4 reg 5
// - battery overvoltage: converter off, fault bits set, fault pulse
// - battery at overvoltage exit clears fault and charging resumes
`ifndef CHARGER_SUPERVISOR_REGS_SVH
`define CHARGER_SUPERVISOR_REGS_SVH
`define REG_STATUS_CONTROL  8'h00
`define REG_SPECIAL_CHARGER 8'h05
`define FLD_FAULT_LO        0
`define FLD_FAULT_HI        2
`define FLD_SPECIAL_FLAG    4
`define FLD_HZ_MODE         1
`define FLD_BOOST_MODE      0
`define CODE_NO_FAULT       3'h0
`define CODE_INPUT_OVP      3'h1
`define CODE_OUTPUT_OVP     3'h2
`define CODE_BAD_ADAPTOR    3'h3
`define RST_STATUS_CONTROL  8'h00
`define RST_SPECIAL_CHARGER 8'h00
`define CLK_MHZ             100
`define QUAL_MS             30
`define RETRY_MS            32
`define PULSE_US            128
`define HOST_WD_S           32
`define SAFETY_MIN          15
`endif

// File: hdl/charger_supervisor_pkg.sv
// types shared by the supervisor and its bench
package charger_supervisor_pkg;
    typedef enum logic [1:0] {
        op_charge,
        op_boost,
        op_hiz
    } op_mode_e;
    typedef enum {
        st_por,
        st_detect,
        st_bad_wait,
        st_run,
        st_sleep
    } adapt_state_e;
    typedef struct packed {
        logic input_ok_min;
        logic input_ovp;
        logic input_below_sleep;
        logic input_at_dpm;
        logic battery_ovp;
    } comparators_s;
    typedef struct packed {
        logic converter_on;
        logic reverse_block_switch;
        logic current_sink;
        logic dpm_reduce;
        logic boost_on;
    } power_ctrl_s;
endpackage

// File: hdl/charger_mode_fault_supervisor.sv
// supervisory control of a one-cell charger: modes, adaptor check, faults
// comparators are asynchronous; register port is a simple byte port
// driven by the serial interface decoder in the same clock domain
`timescale 1ns/10ps
`include "charger_supervisor_regs.svh"
module charger_mode_fault_supervisor
    import charger_supervisor_pkg::*;
#(
    parameter bit          HAS_BOOST   = 1'b1,
    parameter int unsigned QUAL_CYC    = `QUAL_MS * `CLK_MHZ * 1000,
    parameter int unsigned RETRY_CYC   = `RETRY_MS * `CLK_MHZ * 1000,
    parameter int unsigned PULSE_CYC   = `PULSE_US * `CLK_MHZ,
    parameter longint unsigned WD_CYC  = 64'(`HOST_WD_S) * `CLK_MHZ * 1000000
)(
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic         clock_en,
    input  wire comparators_s cmp_async,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    output logic [7:0]        reg_rdata,
    output power_ctrl_s       power,
    output logic              fault_pulse,
    output logic              host_mode,
    output op_mode_e          op_mode
);
    comparators_s cmp_meta;
    comparators_s cmp;
    adapt_state_e state;
    logic [31:0]  tmr;
    logic [31:0]  pulse_cnt;
    logic [63:0]  wd_cnt;
    logic [2:0]   fault_code;
    logic [7:0]   ctrl;
    logic         special_flag;
    logic         in_ovp;
    logic         out_ovp;
    logic         pulse_req;
    op_mode_e     mode_sel;

    always_ff @(posedge clock) begin
        if (srst) begin
            cmp_meta <= '0;
            cmp      <= '0;
        end else if (clock_en) begin
            cmp_meta <= cmp_async;
            cmp      <= cmp_meta;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state <= st_por;
            tmr   <= '0;
        end else if (clock_en) begin
            unique case (state)
                st_por: begin
                    tmr <= '0;
                    // sync stages reset low, so wait for a live input
                    // first; otherwise detection would fail at once
                    if (cmp.input_ok_min) begin
                        state <= st_detect;
                    end
                end
                st_detect: begin
                    if (!cmp.input_ok_min) begin
                        tmr   <= '0;
                        state <= st_bad_wait;
                    end else if (tmr == QUAL_CYC - 1) begin
                        state <= st_run;
                    end else begin
                        tmr <= tmr + 32'd1;
                    end
                end
                st_bad_wait: begin
                    if (tmr == RETRY_CYC - 1) begin
                        tmr   <= '0;
                        state <= st_detect;
                    end else begin
                        tmr <= tmr + 32'd1;
                    end
                end
                st_run: begin
                    if (!cmp.input_ok_min) begin
                        state <= st_por;
                    end else if (cmp.input_below_sleep) begin
                        state <= st_sleep;
                    end
                end
                st_sleep: begin
                    if (!cmp.input_ok_min) begin
                        state <= st_por;
                    end else if (!cmp.input_below_sleep) begin
                        state <= st_run;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            in_ovp  <= 1'b0;
            out_ovp <= 1'b0;
        end else if (clock_en) begin
            in_ovp  <= cmp.input_ovp;
            out_ovp <= cmp.battery_ovp;
        end
    end

    // fault code and pulse request; a bad adaptor is latched until retry
    always_ff @(posedge clock) begin
        if (srst) begin
            fault_code <= `CODE_NO_FAULT;
            pulse_req  <= 1'b0;
        end else if (clock_en) begin
            pulse_req <= 1'b0;
            if (state == st_detect && !cmp.input_ok_min) begin
                fault_code <= `CODE_BAD_ADAPTOR;
                pulse_req  <= 1'b1;
            end else if (cmp.input_ovp && !in_ovp) begin
                fault_code <= `CODE_INPUT_OVP;
                pulse_req  <= 1'b1;
            end else if (cmp.battery_ovp && !out_ovp) begin
                fault_code <= `CODE_OUTPUT_OVP;
                pulse_req  <= 1'b1;
            end else if (!cmp.input_ovp && !cmp.battery_ovp
                         && state != st_bad_wait) begin
                fault_code <= `CODE_NO_FAULT;
            end
        end
    end

    // fault pulse stretched to its fixed width; a new fault restarts it
    always_ff @(posedge clock) begin
        if (srst) begin
            pulse_cnt   <= '0;
            fault_pulse <= 1'b0;
        end else if (clock_en) begin
            if (pulse_req) begin
                pulse_cnt   <= PULSE_CYC - 1;
                fault_pulse <= 1'b1;
            end else if (pulse_cnt != 0) begin
                pulse_cnt <= pulse_cnt - 32'd1;
            end else begin
                fault_pulse <= 1'b0;
            end
        end
    end

    // host watchdog; expiry falls back to default mode
    always_ff @(posedge clock) begin
        if (srst) begin
            host_mode <= 1'b0;
            wd_cnt    <= '0;
        end else if (clock_en) begin
            if (reg_wr) begin
                host_mode <= 1'b1;
                wd_cnt    <= '0;
            end else if (host_mode && wd_cnt == WD_CYC - 1) begin
                host_mode <= 1'b0;
                wd_cnt    <= '0;
            end else if (host_mode) begin
                wd_cnt <= wd_cnt + 64'd1;
            end
        end
    end

    // host settings discarded when host control lapses
    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl <= `RST_STATUS_CONTROL;
        end else if (clock_en) begin
            if (reg_wr && reg_addr == `REG_STATUS_CONTROL) begin
                ctrl <= reg_wdata;
            end else if (!host_mode) begin
                ctrl <= `RST_STATUS_CONTROL;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            special_flag <= 1'b0;
        end else if (clock_en) begin
            special_flag <= cmp.input_at_dpm && state == st_run;
        end
    end

    // mode selection; boost only on boost variants
    always_comb begin
        if (ctrl[`FLD_HZ_MODE]) begin
            mode_sel = op_hiz;
        end else if (ctrl[`FLD_BOOST_MODE] && HAS_BOOST) begin
            mode_sel = op_boost;
        end else begin
            mode_sel = op_charge;
        end
    end

    // power controls registered
    always_ff @(posedge clock) begin
        if (srst) begin
            power   <= '0;
            op_mode <= op_hiz;
        end else if (clock_en) begin
            op_mode <= mode_sel;
            power.current_sink <= (state == st_detect);
            power.reverse_block_switch <= (state == st_run);
            power.converter_on <= state == st_run && mode_sel == op_charge
                                  && !cmp.input_ovp && !cmp.battery_ovp;
            power.boost_on <= mode_sel == op_boost && !cmp.battery_ovp;
            power.dpm_reduce <= cmp.input_at_dpm && state == st_run;
        end
    end

    // register read data
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (clock_en && reg_rd) begin
            if (reg_addr == `REG_STATUS_CONTROL) begin
                reg_rdata <= ctrl;
                reg_rdata[`FLD_FAULT_HI:`FLD_FAULT_LO] <= fault_code;
            end else if (reg_addr == `REG_SPECIAL_CHARGER) begin
                reg_rdata <= 8'h00;
                reg_rdata[`FLD_SPECIAL_FLAG] <= special_flag;
            end else begin
                reg_rdata <= '0;
            end
        end
    end

    property p_bad_sink;
        @(posedge clock) disable iff (srst)
        clock_en && state == st_detect && !cmp.input_ok_min
        ##1 clock_en |=> !power.current_sink;
    endproperty
    a_bad_sink: assert property (p_bad_sink) else $error("sink stays on");

    property p_bad_code;
        @(posedge clock) disable iff (srst)
        clock_en && state == st_detect && !cmp.input_ok_min
        |=> fault_code == `CODE_BAD_ADAPTOR && pulse_req;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("bad code");

    property p_no_early;
        @(posedge clock) disable iff (srst)
        clock_en && state != st_run |=> !power.converter_on;
    endproperty
    a_no_early: assert property (p_no_early) else $error("early");

    property p_in_ovp;
        @(posedge clock) disable iff (srst)
        clock_en && cmp.input_ovp |=> !power.converter_on;
    endproperty
    a_in_ovp: assert property (p_in_ovp) else $error("converter on in ovp");

    property p_out_ovp;
        @(posedge clock) disable iff (srst)
        clock_en && cmp.battery_ovp |=> !power.converter_on;
    endproperty
    a_out_ovp: assert property (p_out_ovp) else $error("converter on");

    property p_sleep;
        @(posedge clock) disable iff (srst)
        clock_en && state == st_sleep |=> !power.reverse_block_switch;
    endproperty
    a_sleep: assert property (p_sleep) else $error("switch on in sleep");

    property p_hiz;
        @(posedge clock) disable iff (srst)
        clock_en && mode_sel == op_hiz |=> !power.converter_on && !power.boost_on;
    endproperty
    a_hiz: assert property (p_hiz) else $error("converter on in high-z");

    property p_noboost;
        @(posedge clock) disable iff (srst)
        !HAS_BOOST |-> op_mode != op_boost;
    endproperty
    a_noboost: assert property (p_noboost) else $error("boost on variant");

    property p_pulse;
        @(posedge clock) disable iff (srst)
        clock_en && pulse_req |=> fault_pulse;
    endproperty
    a_pulse: assert property (p_pulse) else $error("no fault pulse");

    property p_default;
        @(posedge clock) disable iff (srst)
        clock_en && !host_mode && !reg_wr |=> ctrl == `RST_STATUS_CONTROL;
    endproperty
    a_default: assert property (p_default) else $error("ctrl not default");
endmodule

// File: test/host_model.sv
// host processor model on the byte register port of the supervisor
// assumes the supervisor takes strobes on the rising clock edge
`timescale 1ns/10ps
module host_model (
    input  wire logic       clock,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // host traffic, one byte a strobe
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        // released lines flip so a stale value is never read as valid
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask
    // register read, data one cycle on
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

// File: test/testbench.sv
// self-checking bench for the charger supervisor
// assumes host_model on the register port, short counts by parameter
`timescale 1ns/10ps
module testbench
    import charger_supervisor_pkg::*;
;
    localparam int PULSE = 4;
    localparam int WD    = 400;
    logic         clock;
    logic         srst;
    logic         clock_en;
    comparators_s cmp;
    logic         reg_wr;
    logic         reg_rd;
    logic [7:0]   reg_addr;
    logic [7:0]   reg_wdata;
    logic [7:0]   reg_rdata;
    power_ctrl_s  power;
    logic         fault_pulse;
    logic         host_mode;
    op_mode_e     op_mode;
    logic [7:0]   rd;
    int           n_mismatch;
    int           check_count;

    charger_mode_fault_supervisor #(
        .QUAL_CYC  (20),
        .RETRY_CYC (20),
        .PULSE_CYC (PULSE),
        .WD_CYC    (64'(WD))
    ) u_charger_mode_fault_supervisor (
        .clock       (clock),
        .srst        (srst),
        .clock_en    (clock_en),
        .cmp_async   (cmp),
        .reg_wr      (reg_wr),
        .reg_rd      (reg_rd),
        .reg_addr    (reg_addr),
        .reg_wdata   (reg_wdata),
        .reg_rdata   (reg_rdata),
        .power       (power),
        .fault_pulse (fault_pulse),
        .host_mode   (host_mode),
        .op_mode     (op_mode)
    );
    host_model u_host_model (
        .clock     (clock),
        .reg_wr    (reg_wr),
        .reg_rd    (reg_rd),
        .reg_addr  (reg_addr),
        .reg_wdata (reg_wdata),
        .reg_rdata (reg_rdata)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // bounded wait, the comparator path has a few cycles of latency
    task automatic wait_conv(input logic v);
        for (int i = 0; i < 40 && power.converter_on !== v; i++)
            tick(1);
    endtask
    task automatic pulse_check();
        int n;
        n = 0;
        for (int i = 0; i < 12 && fault_pulse !== 1'b1; i++)
            tick(1);
        while (fault_pulse === 1'b1 && n < 20) begin
            n++;
            tick(1);
        end
        check(32'(n), 32'(PULSE), "pulse width");
    endtask
    task automatic t_adaptor();
        tick(5);
        check(power.current_sink, 1, "sink at power-up");
        check(power.converter_on, 0, "converter early");
        u_host_model.rd_reg(8'h00, rd);
        check(rd, 8'h00, "reg0 reset");
        u_host_model.rd_reg(8'h05, rd);
        check(rd, 8'h00, "reg5 reset");
        @(posedge clock);
        cmp.input_ok_min <= 1'b0;
        pulse_check();
        check(power.current_sink, 0, "sink after drop");
        u_host_model.rd_reg(8'h00, rd);
        check(rd[2:0], 3'h3, "bad adaptor code");
        @(posedge clock);
        cmp.input_ok_min <= 1'b1;
        for (int i = 0; i < 40 && power.current_sink !== 1'b1; i++)
            tick(1);
        check(power.current_sink, 1, "retry sink");
        check(power.converter_on, 0, "no charge in retry");
        wait_conv(1'b1);
        check(power.converter_on, 1, "good adaptor");
        check(power.reverse_block_switch, 1, "switch on");
    endtask
    task automatic t_fault(input logic batt, input logic [2:0] code);
        @(posedge clock);
        cmp.battery_ovp <= batt;
        cmp.input_ovp   <= !batt;
        pulse_check();
        check(power.converter_on, 0, "ovp converter");
        u_host_model.rd_reg(8'h00, rd);
        check(rd[2:0], code, "ovp code");
        @(posedge clock);
        cmp.battery_ovp <= 1'b0;
        cmp.input_ovp   <= 1'b0;
        wait_conv(1'b1);
        check(power.converter_on, 1, "ovp resume");
        u_host_model.rd_reg(8'h00, rd);
        check(rd[2:0], 3'h0, "ovp cleared");
    endtask
    task automatic t_sleep();
        @(posedge clock);
        clock_en              <= 1'b0;
        cmp.input_below_sleep <= 1'b1;
        tick(8);
        check(power.reverse_block_switch, 1, "frozen");
        @(posedge clock);
        clock_en <= 1'b1;
        tick(6);
        check(power.converter_on, 0, "sleep converter");
        check(power.reverse_block_switch, 0, "sleep switch");
        @(posedge clock);
        cmp.input_below_sleep <= 1'b0;
        wait_conv(1'b1);
        check(power.converter_on, 1, "wake");
    endtask
    task automatic t_dpm();
        @(posedge clock);
        cmp.input_at_dpm <= 1'b1;
        tick(6);
        check(power.dpm_reduce, 1, "dpm reduce");
        u_host_model.rd_reg(8'h05, rd);
        check(rd[4], 1, "dpm flag set");
        @(posedge clock);
        cmp.input_at_dpm <= 1'b0;
        tick(6);
        check(power.dpm_reduce, 0, "dpm release");
        u_host_model.rd_reg(8'h05, rd);
        check(rd[4], 0, "dpm flag clear");
    endtask
    task automatic t_host();
        u_host_model.wr_reg(8'h00, 8'h02);
        tick(3);
        check(host_mode, 1, "host mode");
        check(op_mode, op_hiz, "high-z");
        check(power.converter_on, 0, "high-z converter");
        u_host_model.wr_reg(8'h00, 8'h01);
        tick(3);
        check(op_mode, op_boost, "boost");
        check(power.boost_on, 1, "boost on");
        u_host_model.wr_reg(8'h00, 8'h00);
        tick(3);
        check(op_mode, op_charge, "charge");
        u_host_model.wr_reg(8'h3c, 8'hff);
        u_host_model.rd_reg(8'h3c, rd);
        check(rd, 8'h00, "unmapped");
        u_host_model.wr_reg(8'h00, 8'h02);
        tick(WD + 20);
        check(host_mode, 0, "watchdog expiry");
        wait_conv(1'b1);
        check(power.converter_on, 1, "default charge");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        finish_test();
    end
    initial begin
        n_mismatch       = 0;
        check_count      = 0;
        srst             = 1'b1;
        clock_en         = 1'b1;
        cmp              = '0;
        cmp.input_ok_min = 1'b1;
        repeat (10) @(posedge clock);
        check(op_mode, op_hiz, "reset mode");
        srst <= 1'b0;
        t_adaptor();
        t_fault(1'b0, 3'h1);
        t_fault(1'b1, 3'h2);
        t_sleep();
        t_dpm();
        t_host();
        finish_test();
    end
endmodule
